// ===== rtl/ldr_params.svh
// Constants for the configuration default loader
`ifndef LDR_PARAMS_SVH
`define LDR_PARAMS_SVH

// ----------------------------------------
// Serial bus
// ----------------------------------------
`define LD_EE_DEV_ADDR 7'h50
`define LD_RW_WRITE 1'b0
`define LD_RW_READ 1'b1
`define LD_CLK_PERIOD_NS 10
`define LD_SCL_PERIOD_NS 10000
`define LD_QUARTER_CYC (`LD_SCL_PERIOD_NS / (4 * `LD_CLK_PERIOD_NS))
`define LD_ACK_BIT 4'h8
`define LD_LAST_DATA_BIT 4'h7
`define LD_WARM_CNT 2'h3

// ----------------------------------------
// EEPROM offsets
// ----------------------------------------
`define LD_OFS_FIRST 8'h21
`define LD_OFS_LAST 8'h3D
`define LD_OFS_CMD 8'h21
`define LD_OFS_SSVID0 8'h22
`define LD_OFS_SSVID1 8'h23
`define LD_OFS_SSID0 8'h24
`define LD_OFS_SSID1 8'h25
`define LD_OFS_LBASE0 8'h26
`define LD_OFS_LBASE1 8'h27
`define LD_OFS_LBASE2 8'h28
`define LD_OFS_LBASE3 8'h29
`define LD_OFS_SYS0 8'h2A
`define LD_OFS_SYS1 8'h2B
`define LD_OFS_SYS3 8'h2D
`define LD_OFS_MF0 8'h2E
`define LD_OFS_MF1 8'h2F
`define LD_OFS_MF2 8'h30
`define LD_OFS_MF3 8'h31
`define LD_OFS_RETRY 8'h32
`define LD_OFS_CARD 8'h33
`define LD_OFS_DEV 8'h34
`define LD_OFS_DIAG 8'h35
`define LD_OFS_PM 8'h36
`define LD_OFS_IDREV 8'h39
`define LD_OFS_GC0 8'h3A
`define LD_OFS_GC1 8'h3B
`define LD_OFS_GPE 8'h3C
`define LD_OFS_GPO 8'h3D

// ----------------------------------------
// Field masks
// ----------------------------------------
`define LD_MASK_RETRY 8'hC0
`define LD_MASK_CARD 8'h80
`define LD_MASK_DEV 8'h6F
`define LD_MASK_DIAG 8'h9F
`define LD_MASK_GC0 8'h0B
`define LD_MASK_GC1 8'h04
`define LD_MASK_GPE 8'hDF
`define LD_MASK_GPO 8'h1F

// ----------------------------------------
// Register port
// ----------------------------------------
`define LD_REG_CTRL 8'h00
`define LD_REG_STATUS 8'h04
`define LD_REG_IDS 8'h08
`define LD_REG_CMD 8'h0C
`define LD_CTRL_RELOAD 0

`endif

// ===== rtl/ldr_pkg.sv
// Types for the configuration default loader
`default_nettype none
package ldr_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_TX    = 5'b00100,
    ST_RX    = 5'b01000,
    ST_STOP  = 5'b10000
  } ldr_state_t;

  typedef struct packed {
    logic [8:0] cmd;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    logic [31:0] legacy_base;
    logic [31:0] sys_ctrl;
    logic [31:0] mfunc_route;
    logic [7:0] retry_status;
    logic [7:0] card_ctrl;
    logic [7:0] dev_ctrl;
    logic [7:0] diag;
    logic pm_cap_b15;
    logic [7:0] legacy_id_rev;
    logic [15:0] gen_ctrl;
    logic [7:0] gpe_enable;
    logic [4:0] gpo;
  } cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } pin_drv_t;
endpackage
`default_nettype wire

// ===== rtl/eeprom_register_default_loader.sv
// Reset-time loader of register defaults from a serial EEPROM
`include "ldr_params.svh"
`default_nettype none
module eeprom_register_default_loader #(
  parameter logic [11:0] QUARTER_CYC = 12'(`LD_QUARTER_CYC)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire ldr_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  // Serial bus pins and presence strap
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sbus_present,
  output ldr_pkg::pin_drv_t pins,
  // Loaded configuration and status
  output ldr_pkg::cfg_t cfg,
  output logic load_busy,
  output logic load_done,
  output logic load_nack
);
  import ldr_pkg::*;

  typedef struct packed {
    ldr_state_t st;
    logic [1:0] q;
    logic [11:0] tmr;
    logic [3:0] bitn;
    logic [1:0] phase;
    logic [7:0] sh;
    logic [7:0] ofs;
    logic ack;
    logic pending;
    logic busy;
    logic done;
    logic nack;
    logic [2:0] sync_scl;
    logic [2:0] sync_sda;
    logic [2:0] sync_det;
    logic scl_f;
    logic sda_f;
    logic det_f;
    logic [1:0] warm;
    pin_drv_t drv;
    logic [31:0] rdata;
    cfg_t cfg;
  } core_t;

  localparam core_t CORE_RST = '{
    st: ST_IDLE, q: 2'h0, tmr: 12'h000, bitn: 4'h0, phase: 2'h0, sh: 8'h00, ofs: 8'h00,
    ack: 1'b0, pending: 1'b1, busy: 1'b0, done: 1'b0, nack: 1'b0, warm: 2'h0,
    sync_scl: 3'h7, sync_sda: 3'h7, sync_det: 3'h0, scl_f: 1'b1, sda_f: 1'b1, det_f: 1'b0,
    drv: '{scl_oe: 1'b0, sda_oe: 1'b0}, rdata: 32'h0000_0000, cfg: '0
  };

  core_t s_reg;
  core_t s_next;

  // Merge masked bits into an old byte
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] d, input logic [7:0] m);
    merge8 = (old & ~m) | (d & m);
  endfunction

  // Place one EEPROM byte into its configuration field
  function automatic cfg_t apply_byte(input cfg_t c, input logic [7:0] ofs, input logic [7:0] d);
    cfg_t r;
    r = c;
    case (ofs)
      `LD_OFS_CMD: r.cmd = {d[7], c.cmd[7], d[6], d[5], c.cmd[4:3], d[2:0]};
      `LD_OFS_SSVID0: r.ssvid[7:0] = d;
      `LD_OFS_SSVID1: r.ssvid[15:8] = d;
      `LD_OFS_SSID0: r.ssid[7:0] = d;
      `LD_OFS_SSID1: r.ssid[15:8] = d;
      `LD_OFS_LBASE0: r.legacy_base[7:0] = d;
      `LD_OFS_LBASE1: r.legacy_base[15:8] = d;
      `LD_OFS_LBASE2: r.legacy_base[23:16] = d;
      `LD_OFS_LBASE3: r.legacy_base[31:24] = d;
      `LD_OFS_SYS0: r.sys_ctrl[7:0] = d;
      `LD_OFS_SYS1: r.sys_ctrl[15:8] = d;
      `LD_OFS_SYS3: r.sys_ctrl[31:24] = d;
      `LD_OFS_MF0: r.mfunc_route[7:0] = d;
      `LD_OFS_MF1: r.mfunc_route[15:8] = d;
      `LD_OFS_MF2: r.mfunc_route[23:16] = d;
      `LD_OFS_MF3: r.mfunc_route[31:24] = d;
      `LD_OFS_RETRY: r.retry_status = merge8(c.retry_status, d, `LD_MASK_RETRY);
      `LD_OFS_CARD: r.card_ctrl = merge8(c.card_ctrl, d, `LD_MASK_CARD);
      `LD_OFS_DEV: r.dev_ctrl = merge8(c.dev_ctrl, d, `LD_MASK_DEV);
      `LD_OFS_DIAG: r.diag = merge8(c.diag, d, `LD_MASK_DIAG);
      `LD_OFS_PM: r.pm_cap_b15 = d[7];
      `LD_OFS_IDREV: r.legacy_id_rev = d;
      `LD_OFS_GC0: r.gen_ctrl[7:0] = merge8(c.gen_ctrl[7:0], d, `LD_MASK_GC0);
      // general control byte 1 bit 2
      `LD_OFS_GC1: r.gen_ctrl[15:8] = merge8(c.gen_ctrl[15:8], d, `LD_MASK_GC1);
      `LD_OFS_GPE: r.gpe_enable = merge8(c.gpe_enable, d, `LD_MASK_GPE);
      `LD_OFS_GPO: r.gpo = 5'(merge8({3'h0, c.gpo}, d, `LD_MASK_GPO));
      // Offsets without a field, reserved ones included
      default: r = c;
    endcase
    apply_byte = r;
  endfunction

  // Next-state logic
  always_comb begin
    logic tick;
    logic stall;
    logic [7:0] nsh;
    tick = 1'b0;
    stall = 1'b0;
    nsh = 8'h00;
    s_next = s_reg;

    // Three-stage input synchronisers, change taken when stages 2 and 3 agree
    // Stage 1 feeds only stage 2
    s_next.sync_scl = {s_reg.sync_scl[1:0], scl_in};
    s_next.sync_sda = {s_reg.sync_sda[1:0], sda_in};
    s_next.sync_det = {s_reg.sync_det[1:0], sbus_present};
    if (s_reg.sync_scl[2] == s_reg.sync_scl[1]) begin
      s_next.scl_f = s_reg.sync_scl[2];
    end
    if (s_reg.sync_sda[2] == s_reg.sync_sda[1]) begin
      s_next.sda_f = s_reg.sync_sda[2];
    end
    if (s_reg.sync_det[2] == s_reg.sync_det[1]) begin
      s_next.det_f = s_reg.sync_det[2];
    end

    // Count edges until the strap has filled the synchroniser
    if (s_reg.warm != `LD_WARM_CNT) begin
      s_next.warm = s_reg.warm + 2'h1;
    end

    // Quarter-bit timer, held while a slave stretches the clock
    stall = !s_reg.drv.scl_oe && !s_reg.scl_f;
    // A tick ends each quarter of a bit
    if (s_reg.st != ST_IDLE) begin
      if (s_reg.tmr >= QUARTER_CYC - 12'h001) begin
        tick = !stall;
        if (!stall) begin
          s_next.tmr = 12'h000;
          s_next.q = s_reg.q + 2'h1;
        end
      end else begin
        s_next.tmr = s_reg.tmr + 12'h001;
      end
    end

    // Sequencer
    case (s_reg.st)
      ST_IDLE: begin
        // Bus released; wait for a pending load
        s_next.drv = '{scl_oe: 1'b0, sda_oe: 1'b0};
        s_next.q = 2'h0;
        s_next.tmr = 12'h000;
        // load starts only with interface present
        // Strap judged only once the synchroniser has filled
        if (s_reg.pending && s_reg.warm == `LD_WARM_CNT && s_reg.sync_det[2] == s_reg.sync_det[1]) begin
          s_next.pending = 1'b0;
          if (s_reg.sync_det[2]) begin
            s_next.st = ST_START;
            s_next.busy = 1'b1;
            s_next.done = 1'b0;
            s_next.nack = 1'b0;
            s_next.phase = 2'h0;
            s_next.sh = {`LD_EE_DEV_ADDR, `LD_RW_WRITE};
          end else begin
            s_next.done = 1'b1;
          end
        end
      end
      ST_START: begin
        // Start or repeated start: release SDA, raise SCL, pull SDA, pull SCL
        if (tick) begin
          case (s_reg.q)
            2'h0: s_next.drv.sda_oe = 1'b0;
            2'h1: s_next.drv.scl_oe = 1'b0;
            2'h2: s_next.drv.sda_oe = 1'b1;
            // Clock low, first bit on SDA
            default: begin
              s_next.drv.scl_oe = 1'b1;
              s_next.drv.sda_oe = ~s_reg.sh[7];
              s_next.bitn = 4'h0;
              s_next.st = ST_TX;
            end
          endcase
        end
      end
      ST_TX: begin
        // Shift out one bit per four quarters, MSB first
        if (tick) begin
          case (s_reg.q)
            2'h0: s_next.drv.scl_oe = 1'b0;
            2'h1: s_next.ack = s_reg.sda_f;
            // Clock low again
            2'h2: s_next.drv.scl_oe = 1'b1;
            default: begin
              // Next data bit, or SDA released for the acknowledge
              if (s_reg.bitn != `LD_ACK_BIT) begin
                nsh = {s_reg.sh[6:0], 1'b0};
                s_next.sh = nsh;
                s_next.bitn = s_reg.bitn + 4'h1;
                s_next.drv.sda_oe = (s_reg.bitn == `LD_LAST_DATA_BIT) ? 1'b0 : ~nsh[7];
              end else if (s_reg.ack) begin
                // No acknowledge: abandon the load
                s_next.nack = 1'b1;
                s_next.drv.sda_oe = 1'b1;
                s_next.st = ST_STOP;
              end else begin
                s_next.bitn = 4'h0;
                case (s_reg.phase)
                  // Device address taken: send the first word offset
                  2'h0: begin
                    nsh = `LD_OFS_FIRST;
                    s_next.phase = 2'h1;
                    s_next.sh = nsh;
                    s_next.drv.sda_oe = ~nsh[7];
                  end
                  // Offset taken: repeated start for reading
                  2'h1: begin
                    s_next.phase = 2'h2;
                    s_next.sh = {`LD_EE_DEV_ADDR, `LD_RW_READ};
                    s_next.st = ST_START;
                  end
                  // Read address taken: collect bytes
                  default: begin
                    s_next.ofs = `LD_OFS_FIRST;
                    s_next.drv.sda_oe = 1'b0;
                    s_next.st = ST_RX;
                  end
                endcase
              end
            end
          endcase
        end
      end
      ST_RX: begin
        // Shift in one bit per four quarters, MSB first
        if (tick) begin
          case (s_reg.q)
            2'h0: s_next.drv.scl_oe = 1'b0;
            // Sample data, never the acknowledge slot
            2'h1: begin
              if (s_reg.bitn != `LD_ACK_BIT) begin
                s_next.sh = {s_reg.sh[6:0], s_reg.sda_f};
              end
            end
            // Clock low again
            2'h2: s_next.drv.scl_oe = 1'b1;
            default: begin
              if (s_reg.bitn != `LD_ACK_BIT) begin
                s_next.bitn = s_reg.bitn + 4'h1;
                // Acknowledge all but the final byte
                s_next.drv.sda_oe = (s_reg.bitn == `LD_LAST_DATA_BIT) && (s_reg.ofs != `LD_OFS_LAST);
              end else begin
                // Byte complete: place it and move on
                s_next.cfg = apply_byte(s_reg.cfg, s_reg.ofs, s_reg.sh);
                s_next.bitn = 4'h0;
                if (s_reg.ofs == `LD_OFS_LAST) begin
                  s_next.drv.sda_oe = 1'b1;
                  s_next.st = ST_STOP;
                end else begin
                  s_next.ofs = s_reg.ofs + 8'h01;
                  s_next.drv.sda_oe = 1'b0;
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        // Stop: raise SCL then release SDA
        if (tick) begin
          case (s_reg.q)
            // SCL up while SDA stays low
            2'h0: s_next.drv.scl_oe = 1'b0;
            // SDA up with SCL high: stop
            2'h2: s_next.drv.sda_oe = 1'b0;
            // Load finished: report and go idle
            2'h3: begin
              s_next.busy = 1'b0;
              s_next.done = 1'b1;
              s_next.st = ST_IDLE;
            end
            default: s_next.drv = s_reg.drv;
          endcase
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // Register port: a reload request wins over the clear in idle
    if (bus.wr && bus.addr == `LD_REG_CTRL && bus.wdata[`LD_CTRL_RELOAD]) begin
      s_next.pending = 1'b1;
    end
    // Read data for one cycle, zero otherwise
    s_next.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `LD_REG_CTRL: s_next.rdata = {31'h0000_0000, s_reg.pending};
        `LD_REG_STATUS: s_next.rdata = {28'h000_0000, s_reg.det_f, s_reg.nack, s_reg.done, s_reg.busy};
        `LD_REG_IDS: s_next.rdata = {s_reg.cfg.ssid, s_reg.cfg.ssvid};
        `LD_REG_CMD: s_next.rdata = {23'h00_0000, s_reg.cfg.cmd};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= CORE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign rdata = s_reg.rdata;
  assign pins = s_reg.drv;
  assign cfg = s_reg.cfg;
  assign load_busy = s_reg.busy;
  assign load_done = s_reg.done;
  assign load_nack = s_reg.nack;
endmodule
`default_nettype wire

// ===== tb/loader_assertions.sv
// Concurrent checks on the ports of the configuration default loader
`default_nettype none
module loader_assertions #(
  parameter logic [11:0] QUARTER_CYC = 12'h0FA
) (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic nrst,
  input wire ldr_pkg::bus_req_t bus,
  input wire logic [31:0] rdata,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sbus_present,
  input wire ldr_pkg::pin_drv_t pins,
  // Results
  input wire ldr_pkg::cfg_t cfg,
  input wire logic load_busy,
  input wire logic load_done,
  input wire logic load_nack
);
  import ldr_pkg::*;
  logic [11:0] gap_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Cycles since the pin drivers last moved
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 12'hFFF;
    end else if ($changed(pins)) begin
      gap_reg <= 12'h000;
    end else if (gap_reg != 12'hFFF) begin
      gap_reg <= gap_reg + 12'h001;
    end
  end
  property p_pin_gap;
    $changed(pins) |-> gap_reg >= QUARTER_CYC - 12'h001;
  endproperty
  a_pin_gap: assert property (p_pin_gap) else $error("pin drivers moved inside a quarter");
  property p_idle_bus;
    !load_busy && !$past(load_busy) |-> !pins.scl_oe && !pins.sda_oe;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("pins driven outside a load");
  property p_ids_read;
    bus.rd && bus.addr == 8'h08 && !load_busy |=> rdata == {cfg.ssid, cfg.ssvid};
  endproperty
  a_ids_read: assert property (p_ids_read) else $error("identity read differs");
  property p_cfg_steady;
    !load_busy && !$past(load_busy) |-> $stable(cfg);
  endproperty
  a_cfg_steady: assert property (p_cfg_steady) else $error("fields moved outside a load");
  property p_nack_done;
    load_nack && !load_busy |-> load_done;
  endproperty
  a_nack_done: assert property (p_nack_done) else $error("refusal without done");
  property p_cmd_gap;
    cfg.cmd[7] == 1'b0 && cfg.cmd[4:3] == 2'b00;
  endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("command gap bits set");
  property p_sys_gap;
    cfg.sys_ctrl[23:16] == 8'h00;
  endproperty
  a_sys_gap: assert property (p_sys_gap) else $error("system control byte 2 set");
  property p_field_gaps;
    {cfg.retry_status[5:0], cfg.card_ctrl[6:0], cfg.dev_ctrl[7], cfg.dev_ctrl[4], cfg.diag[6:5]} == 17'h0_0000;
  endproperty
  a_field_gaps: assert property (p_field_gaps) else $error("unloaded bits set");
  property p_gen_gaps;
    (cfg.gen_ctrl & 16'hFBF4) == 16'h0000 && cfg.gpe_enable[5] == 1'b0;
  endproperty
  a_gen_gaps: assert property (p_gen_gaps) else $error("control gap bits set");
endmodule
`default_nettype wire

// ===== tb/ee_model.sv
// Behavioural serial EEPROM that answers on the two-wire bus
`default_nettype none
module ee_model (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  // Strap and pacing
  input wire logic [6:0] strap,
  input wire logic [15:0] stretch_ns,
  // Drivers, high pulls low
  output logic sda_oe,
  output logic scl_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act, rd, go_rd, ok, wph;
  int n;
  initial begin
    sda_oe = 1'b0;
    scl_hold = 1'b0;
    act = 1'b0;
  end
  // Start and stop conditions
  // Judged just after the edge: SCL falling in the same step is no condition
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) begin
      act = 1'b1;
      n = 0;
      rd = 1'b0;
      go_rd = 1'b0;
      wph = 1'b0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1) act = 1'b0;
  end
  // Sample bits on the rising clock
  always @(posedge scl) begin
    if (act) begin
      if (n < 8) sh = {sh[6:0], sda};
      if (n == 7 && !rd && !wph) begin
        ok = sh[7:1] == strap;
        go_rd = ok && sh[0];
      end
      if (n == 7 && !rd && wph) begin
        ptr = sh;
        ok = 1'b1;
      end
      if (n == 7) wph = 1'b1;
      if (n == 8 && rd && sda) act = 1'b0;
      n = n + 1;
    end
  end
  // Drive ack or data while the clock is low
  always @(negedge scl) begin
    if (act) begin
      if (n == 9) begin
        n = 0;
        rd = go_rd;
      end
      sda_oe <= rd ? (n < 8 && !mem[ptr][7 - n]) : (n == 8 && ok);
      if (rd && n == 8) ptr = ptr + 8'h01;
    end
  end
  // Slow answer by holding the clock low
  always @(negedge scl) begin
    if (act && stretch_ns != 16'h0000) begin
      scl_hold = 1'b1;
      #(stretch_ns) scl_hold = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/eeprom_register_default_loader_bench.sv
// Self-checking bench of the configuration default loader
`default_nettype none
module eeprom_register_default_loader_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ldr_pkg::*;
  logic mclk, nrst, sbus_present, scl_in, sda_in, ee_sda_oe, ee_scl_hold;
  logic [31:0] rdata, seed;
  logic [6:0] strap;
  logic [15:0] stretch_ns;
  logic rd_seen, done_d;
  bus_req_t bus;
  pin_drv_t pins;
  cfg_t cfg, exp_c;
  logic load_busy, load_done, load_nack;
  int n_fail, tests_run, cycles;
  cfg_t cfg_q[$];
  logic [31:0] rd_q[$];
  // Open-drain wires with pull-ups
  assign scl_in = ~(pins.scl_oe | ee_scl_hold);
  assign sda_in = ~(pins.sda_oe | ee_sda_oe);
  eeprom_register_default_loader #(.QUARTER_CYC(12'h004)) i_eeprom_register_default_loader (.mclk(mclk),
    .nrst(nrst), .bus(bus), .rdata(rdata), .scl_in(scl_in), .sda_in(sda_in), .sbus_present(sbus_present),
    .pins(pins), .cfg(cfg), .load_busy(load_busy), .load_done(load_done), .load_nack(load_nack));
  ee_model i_ee_model (.scl(scl_in), .sda(sda_in), .strap(strap), .stretch_ns(stretch_ns),
    .sda_oe(ee_sda_oe), .scl_hold(ee_scl_hold));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected fields from the EEPROM image
  function automatic cfg_t want();
    cfg_t c;
    logic [7:0] m [0:255];
    m = i_ee_model.mem;
    c = '0;
    c.cmd = {m[8'h21][7], 1'b0, m[8'h21][6:5], 2'b00, m[8'h21][2:0]};
    c.ssvid = {m[8'h23], m[8'h22]};
    c.ssid = {m[8'h25], m[8'h24]};
    c.legacy_base = {m[8'h29], m[8'h28], m[8'h27], m[8'h26]};
    c.sys_ctrl = {m[8'h2D], 8'h00, m[8'h2B], m[8'h2A]};
    c.mfunc_route = {m[8'h31], m[8'h30], m[8'h2F], m[8'h2E]};
    c.retry_status = m[8'h32] & 8'hC0;
    c.card_ctrl = m[8'h33] & 8'h80;
    c.dev_ctrl = m[8'h34] & 8'h6F;
    c.diag = m[8'h35] & 8'h9F;
    c.pm_cap_b15 = m[8'h36][7];
    c.legacy_id_rev = m[8'h39];
    c.gen_ctrl = {m[8'h3B] & 8'h04, m[8'h3A] & 8'h0B};
    c.gpe_enable = m[8'h3C] & 8'hDF;
    c.gpo = m[8'h3D][4:0];
    return c;
  endfunction
  task automatic fill();
    for (int k = 0; k < 256; k++) begin
      seed = lfsr(seed);
      i_ee_model.mem[k] = (k == 8'h2C || k == 8'h37 || k == 8'h38 || (k >= 8'h3E && k <= 8'h49)) ? 8'h00 : seed[7:0];
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b0};
  endtask
  // Wait for a load to start, then to end
  task automatic settle();
    for (int k = 0; k < 20 && !load_busy; k++) @(posedge mclk);
    for (int k = 0; k < 30000 && !load_done; k++) @(posedge mclk);
    // A load that never ends counts as a mismatch
    if (!load_done) n_fail++;
    @(posedge mclk);
  endtask
  task automatic cmp_cfg(input cfg_t e);
    tests_run++;
    if (cfg !== e) begin
      n_fail++;
      $display("wrong value at %0t: fields %h expected %h", $time, cfg, e);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] e);
    tests_run++;
    if (rdata !== e) begin
      n_fail++;
      $display("wrong value at %0t: read %h expected %h", $time, rdata, e);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Result watcher and cycle ceiling
  always @(posedge mclk) begin
    if (rd_seen) cmp_rd(rd_q.pop_front());
    rd_seen = bus.rd;
    if (load_done && !done_d) cmp_cfg(cfg_q.size() ? cfg_q.pop_front() : cfg_t'('x));
    done_d = load_done;
    cycles++;
    if (cycles > 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    bus = '0;
    nrst = 1'b0;
    sbus_present = 1'b1;
    strap = 7'h50;
    stretch_ns = 16'h0000;
    seed = 32'h69b9;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    rd_seen = 1'b0;
    done_d = 1'b0;
    fill();
    exp_c = want();
    cfg_q.push_back(exp_c);
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    rd(8'h04, 32'h0000_000A);
    rd(8'h08, {exp_c.ssid, exp_c.ssvid});
    rd(8'h0C, {23'h00_0000, exp_c.cmd});
    rd(8'h10, 32'h0000_0000);
    wr(8'h10, lfsr(seed));
    rd(8'h08, {exp_c.ssid, exp_c.ssvid});
    rd(8'h00, 32'h0000_0000);
    // Reload with slow answers and a second request mid-load
    fill();
    stretch_ns <= 16'h00C8;
    exp_c = want();
    cfg_q.push_back(exp_c);
    cfg_q.push_back(exp_c);
    wr(8'h00, 32'h0000_0001);
    for (int k = 0; k < 20 && !load_busy; k++) @(posedge mclk);
    wr(8'h00, 32'h0000_0001);
    settle();
    settle();
    rd(8'h0C, {23'h00_0000, exp_c.cmd});
    // Wrong strap: address refused, fields kept
    strap <= 7'h51;
    cfg_q.push_back(exp_c);
    wr(8'h00, 32'h0000_0001);
    settle();
    rd(8'h04, 32'h0000_000E);
    // No serial interface at reset: nothing loaded
    cfg_q.push_back('0);
    @(posedge mclk);
    nrst <= 1'b0;
    sbus_present <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    rd(8'h04, 32'h0000_0002);
    repeat (4) @(posedge mclk);
    // Every noted result must have been met
    if (cfg_q.size() != 0 || rd_q.size() != 0) n_fail++;
    tally_and_finish();
  end
endmodule
bind eeprom_register_default_loader loader_assertions #(.QUARTER_CYC(QUARTER_CYC)) i_loader_assertions (
  .mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata), .scl_in(scl_in), .sda_in(sda_in),
  .sbus_present(sbus_present), .pins(pins), .cfg(cfg), .load_busy(load_busy), .load_done(load_done),
  .load_nack(load_nack));
`default_nettype wire
